// ===== pkg/cwro_regs.vh
// Purpose: Constants for the option word and start-up reset sequencer.
// Assumes: A 40 MHz core clock, period 25 ns.
// Notes: Included by the sequencer; the delay counter does not include it.
// Function
// - Power-up timer holds reset 64 ms after power-up or brown-out
// - Oscillator start-up timer holds until oscillator stable
// - Brown-out resets; may extend with power-up timer
// - Sleep exits on reset, watchdog wake, interrupt
// - Programmed bit reads 0, unprogrammed reads 1
// - Option word lives at location 2007h
// - Configuration space reachable only while programming
// - Bits 15 to 13 always read 1
// - Bit 12 selects wake-continue or wake-reset
// - Bit 11 enables fail-safe clock monitor
// - Bit 10 enables internal/external clock switchover
// - Mode 11 keeps brown-out always on
// - Mode 10 brown-out on when awake only
// - Mode 01 software control; 00 all off
// - Bit 4 low enables the power-up timer
// - Brown-out enable never enables power-up timer
`ifndef CWRO_REGS_VH
`define CWRO_REGS_VH
`define CWRO_OPT_ADDR 14'h2007
`define CWRO_CFG_LO 14'h2000
`define CWRO_CFG_HI 14'h3fff
`define CWRO_OPT_UNIMPL 3'h7
`define CWRO_BIT_WAKE 12
`define CWRO_BIT_FCM 11
`define CWRO_BIT_SWO 10
`define CWRO_BIT_BOR_HI 9
`define CWRO_BIT_BOR_LO 8
`define CWRO_BIT_POWER_UP_TIMER_ENABLE 4
`define CWRO_OPT_RESET 16'hffff
`define CWRO_BOR_ALWAYS 2'h3
`define CWRO_BOR_AWAKE 2'h2
`define CWRO_BOR_SOFT 2'h1
`define CWRO_PUT_MS 64
`define CWRO_CLK_KHZ 40000
`define CWRO_PUT_CYCLES (`CWRO_PUT_MS * `CWRO_CLK_KHZ)
`define CWRO_ST_POR 3'h0
`define CWRO_ST_PUT 3'h1
`define CWRO_ST_OST 3'h2
`define CWRO_ST_RUN 3'h3
`define CWRO_ST_SLEEP 3'h4
`endif

// ===== logic/cwro_delay.v
// Purpose: Loadable down-counter used as the power-up delay.
// Assumes: Start may be held high; the count reloads on every enabled cycle it stays high.
// Notes: Width sized for the longest count.
`timescale 1ns/100ps
module cwro_delay #(
  parameter WIDTH = 24
)
(
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_start,
  input wire [WIDTH-1:0] i_count,
  output wire o_busy
);
  reg [WIDTH-1:0] count_reg;

  // ============================================================
  // Counter
  // Loading on start restarts the delay so a late event extends it.
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      count_reg <= {WIDTH{1'b0}};
    else if (i_ce)
    begin
      if (i_start)
        count_reg <= i_count;
      else if (count_reg != {WIDTH{1'b0}})
        count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign o_busy = (count_reg != {WIDTH{1'b0}});
endmodule

// ===== logic/cwro_seq.v
// Purpose: Option word store and start-up reset sequencer.
// Assumes: Pin inputs are asynchronous and synchronised here.
// Notes: The option word is only reachable in programming mode.
`include "cwro_regs.vh"
`timescale 1ns/100ps
module cwro_seq #(
  parameter PUT_CYCLES = `CWRO_PUT_CYCLES,
  parameter CNT_W = 24
)
(
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_por,
  input wire i_brownout_det,
  input wire i_ext_rst_n,
  input wire i_osc_stable,
  input wire i_prog_mode,
  input wire [13:0] i_prog_addr,
  input wire [15:0] i_prog_wdata,
  input wire i_prog_we,
  input wire i_prog_re,
  input wire i_sleep_req,
  input wire i_wdt_wake,
  input wire i_irq_wake,
  input wire i_software_brownout_enable,
  output reg [15:0] o_prog_rdata,
  output wire o_core_rst,
  output wire o_sleeping,
  output wire o_wake_reset,
  output wire o_clock_fail_monitor_en,
  output wire o_clock_switchover_en,
  output wire o_brownout_reset_en,
  output wire o_software_brownout_avail
);
  // ============================================================
  // Synchronisers
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      sync1_reg <= 5'h10;
      sync2_reg <= 5'h10;
    end
    else if (i_ce)
    begin
      sync1_reg <= {i_ext_rst_n, i_por, i_brownout_det, i_osc_stable, i_prog_mode};
      sync2_reg <= sync1_reg;
    end
  end
  wire ext_rst = ~sync2_reg[4];
  wire por_s = sync2_reg[3];
  wire bod_s = sync2_reg[2];
  wire osc_ok = sync2_reg[1];
  wire prog_s = sync2_reg[0];

  // ============================================================
  // Option word storage
  // Unprogrammed bits read 1, so the store erases to all ones.
  reg [15:0] opt_reg;
  wire opt_hit = (i_prog_addr == `CWRO_OPT_ADDR);
  wire cfg_hit = (i_prog_addr >= `CWRO_CFG_LO) && (i_prog_addr <= `CWRO_CFG_HI);
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      opt_reg <= `CWRO_OPT_RESET;
    else if (i_ce && prog_s && i_prog_we && opt_hit)
      opt_reg <= {`CWRO_OPT_UNIMPL, i_prog_wdata[12:0]};
  end

  // Reads answer one cycle later; outside programming they return ones.
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_prog_rdata <= `CWRO_OPT_RESET;
    else if (i_ce && i_prog_re)
    begin
      if (prog_s && opt_hit)
        o_prog_rdata <= {`CWRO_OPT_UNIMPL, opt_reg[12:0]};
      else if (prog_s && cfg_hit)
        o_prog_rdata <= `CWRO_OPT_RESET;
      else
        o_prog_rdata <= `CWRO_OPT_RESET;
    end
  end

  // ============================================================
  // Sequencer state
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] lat_reg;
  wire put_busy;
  wire put_en = ~lat_reg[`CWRO_BIT_POWER_UP_TIMER_ENABLE];
  wire [1:0] bor_mode = lat_reg[`CWRO_BIT_BOR_HI:`CWRO_BIT_BOR_LO];
  wire asleep = (state_reg == `CWRO_ST_SLEEP);
  reg bor_en;

  // Brown-out enable by mode.
  always @*
  begin
    case (bor_mode)
      `CWRO_BOR_ALWAYS: bor_en = 1'b1;
      `CWRO_BOR_AWAKE: bor_en = ~asleep;
      `CWRO_BOR_SOFT: bor_en = i_software_brownout_enable;
      default: bor_en = 1'b0;
    endcase
  end

  wire bor_trip = bod_s && bor_en;
  wire wake_evt = i_wdt_wake || i_irq_wake;
  wire wake_rst = asleep && wake_evt && ~lat_reg[`CWRO_BIT_WAKE];
  wire hard_rst = por_s || bor_trip || ext_rst || wake_rst || prog_s;
  // Power-up timer reloads while power-on or brown-out is active, never on other resets.
  // Reloading for the whole event means the full delay counts from its release.
  wire put_start = put_en && (por_s || bor_trip);

  cwro_delay #(
    .WIDTH(CNT_W)
  ) u_put (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_start(put_start),
    .i_count(PUT_CYCLES[CNT_W-1:0]),
    .o_busy(put_busy)
  );

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `CWRO_ST_POR:
        if (!hard_rst)
          state_next = `CWRO_ST_PUT;
      `CWRO_ST_PUT:
        if (hard_rst)
          state_next = `CWRO_ST_POR;
        else if (!put_busy)
          state_next = `CWRO_ST_OST;
      `CWRO_ST_OST:
        if (hard_rst)
          state_next = `CWRO_ST_POR;
        else if (osc_ok)
          state_next = `CWRO_ST_RUN;
      `CWRO_ST_RUN:
        if (hard_rst)
          state_next = `CWRO_ST_POR;
        else if (i_sleep_req)
          state_next = `CWRO_ST_SLEEP;
      `CWRO_ST_SLEEP:
        if (hard_rst)
          state_next = `CWRO_ST_POR;
        else if (wake_evt)
          state_next = `CWRO_ST_RUN;
      default:
        state_next = `CWRO_ST_POR;
    endcase
  end

  // ============================================================
  // State and option latch
  // Latching only while held in reset keeps settings fixed in run.
  always @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= `CWRO_ST_POR;
      lat_reg <= `CWRO_OPT_RESET;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      if (state_reg == `CWRO_ST_POR)
        lat_reg <= opt_reg;
    end
  end

  assign o_core_rst = (state_reg != `CWRO_ST_RUN) && !asleep;
  assign o_sleeping = asleep;
  assign o_wake_reset = wake_rst;
  assign o_clock_fail_monitor_en = lat_reg[`CWRO_BIT_FCM];
  assign o_clock_switchover_en = lat_reg[`CWRO_BIT_SWO];
  assign o_brownout_reset_en = bor_en;
  assign o_software_brownout_avail = (bor_mode == `CWRO_BOR_SOFT);
endmodule

// ===== dv/cwro_seq_checker.sv
// Purpose: Port-level checker for the option word sequencer.
// Assumes: One core clock domain; i_ce held high by the bench.
// Notes: Attached to every cwro_seq by the bind below.
`timescale 1ns/100ps
module cwro_chk (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_brownout_det,
  input wire i_ext_rst_n,
  input wire i_osc_stable,
  input wire i_prog_mode,
  input wire i_prog_re,
  input wire i_wdt_wake,
  input wire i_irq_wake,
  input wire i_software_brownout_enable,
  input wire [15:0] o_prog_rdata,
  input wire o_core_rst,
  input wire o_sleeping,
  input wire o_wake_reset,
  input wire o_clock_fail_monitor_en,
  input wire o_clock_switchover_en,
  input wire o_brownout_reset_en,
  input wire o_software_brownout_avail
);
  // ==========================================================
  // Properties
  // Depth of four covers the two-stage pin synchronisers.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rd_ones; $past(i_prog_re) |-> o_prog_rdata[15:13] == 3'h7; endproperty
  a_rd_ones: assert property (p_rd_ones) else $error("top bits not one");
  property p_rd_off; $past(i_prog_re) && !$past(i_prog_mode) && !$past(i_prog_mode, 2) &&
    !$past(i_prog_mode, 3) |-> o_prog_rdata == 16'hffff; endproperty
  a_rd_off: assert property (p_rd_off) else $error("read outside programming");
  property p_prog_rst; i_prog_mode [*4] |-> o_core_rst; endproperty
  a_prog_rst: assert property (p_prog_rst) else $error("core runs in programming");
  property p_stable; !o_core_rst && $past(!o_core_rst) |->
    $stable(o_clock_fail_monitor_en) && $stable(o_clock_switchover_en); endproperty
  a_stable: assert property (p_stable) else $error("option changed in run");
  property p_soft; o_software_brownout_avail |-> o_brownout_reset_en == i_software_brownout_enable; endproperty
  a_soft: assert property (p_soft) else $error("software brownout ignored");
  property p_osc; o_core_rst && !i_osc_stable && $past(!i_osc_stable) && $past(!i_osc_stable, 2)
    |=> o_core_rst; endproperty
  a_osc: assert property (p_osc) else $error("released before oscillator");
  property p_wake; o_sleeping && (i_wdt_wake || i_irq_wake) |-> ##[1:3] !o_sleeping; endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");
  property p_wake_rst; o_wake_reset |-> ##[0:2] o_core_rst; endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake reset missing");
  property p_ext; !i_ext_rst_n [*4] |-> o_core_rst; endproperty
  a_ext: assert property (p_ext) else $error("external reset ignored");
  property p_bor; (i_brownout_det && o_brownout_reset_en) [*4] |-> o_core_rst; endproperty
  a_bor: assert property (p_bor) else $error("brown-out reset ignored");
  c_sleep: cover property (o_sleeping);
  c_wake_rst: cover property (o_wake_reset);
  c_run: cover property ($fell(o_core_rst));
endmodule
bind cwro_seq cwro_chk u_chk (.i_core_clk, .i_sys_rst, .i_brownout_det, .i_ext_rst_n, .i_osc_stable, .i_prog_mode,
  .i_prog_re, .i_wdt_wake, .i_irq_wake, .i_software_brownout_enable, .o_prog_rdata, .o_core_rst,
  .o_sleeping, .o_wake_reset, .o_clock_fail_monitor_en, .o_clock_switchover_en,
  .o_brownout_reset_en, .o_software_brownout_avail);

// ===== dv/tb.sv
// Purpose: Self-checking bench for the option word sequencer.
// Assumes: Short power-up count of 20 cycles.
// Notes: Reads are noted in a queue and checked by a monitor.
`timescale 1ns/100ps
module tb;
  reg clk = 0, rst = 1, por = 1, bod = 0, ext_n = 1, osc = 1, pm = 0;
  reg we = 0, re = 0, slp = 0, wdt = 0, irq = 0, sbo = 0, due = 0;
  reg [13:0] adr = 14'h0000;
  reg [15:0] wd = 16'h0000, lf = 16'h0038, d;
  wire [15:0] rd;
  wire crst, slpg, wrst, fcm, swo, brownout_mode_select, sav;
  int num_errors = 0, num_checks = 0, n;
  logic [15:0] q[$];
  cwro_seq #(.PUT_CYCLES(20)) uut (.i_core_clk(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_por(por),
    .i_brownout_det(bod), .i_ext_rst_n(ext_n), .i_osc_stable(osc), .i_prog_mode(pm), .i_prog_addr(adr),
    .i_prog_wdata(wd), .i_prog_we(we), .i_prog_re(re), .i_sleep_req(slp), .i_wdt_wake(wdt),
    .i_irq_wake(irq), .i_software_brownout_enable(sbo), .o_prog_rdata(rd), .o_core_rst(crst),
    .o_sleeping(slpg), .o_wake_reset(wrst), .o_clock_fail_monitor_en(fcm), .o_clock_switchover_en(swo),
    .o_brownout_reset_en(brownout_mode_select), .o_software_brownout_avail(sav));
  // ==========================================================
  // Clock and helpers
  initial forever #12.5 clk = ~clk;
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Read data appears one cycle after the strobe, so it is judged half a cycle later.
  always @(posedge clk) due <= re;
  always @(negedge clk) if (due) chk(rd, q.pop_front());
  // Programs a word, reads it back to back with a foreign address, then reads outside.
  task prog(input [15:0] v);
    pm = 1; osc = 0; sbo = lf[0]; cyc(3);
    adr = 14'h2007; wd = v; we = 1; cyc(1);
    we = 0; re = 1; q.push_back(v | 16'he000); cyc(1);
    adr = 14'h2000; q.push_back(16'hffff); cyc(1);
    re = 0; pm = 0; cyc(4);
    adr = 14'h2007; re = 1; q.push_back(16'hffff); cyc(1);
    re = 0;
  endtask
  // Counts reset cycles; the oscillator settles five cycles in.
  task run(output int c);
    c = 0;
    while (crst === 1'b1 && c < 200)
    begin
      if (c == 5) osc = 1;
      cyc(1);
      c++;
    end
    if (c >= 200)
    begin
      num_errors++;
      finish_test;
    end
  endtask
  // ==========================================================
  // Main sequence: one round per brown-out mode and wake source.
  initial
  begin
    cyc(3);
    rst = 0;
    for (int m = 0; m < 4; m++)
    begin
      lf = nxt(lf); d = lf; d[9:8] = m; d[4] = (m != 0); d[12] = (m != 3);
      prog(d); por = 0; run(n);
      chk(n >= 20, !d[4]);
      chk({fcm, swo, brownout_mode_select, sav}, {d[11], d[10], m != 0 && (m != 1 || sbo), m == 1});
      slp = 1; cyc(1); slp = 0; cyc(2);
      chk(slpg, 1'b1);
      chk(brownout_mode_select, m == 3 || (m == 1 && sbo));
      wdt = (m == 0); irq = m[0]; ext_n = (m != 2); osc = (m < 2); cyc(m == 2 ? 5 : 1);
      wdt = 0; irq = 0; ext_n = 1; cyc(3);
      chk({slpg, crst}, {1'b0, m >= 2});
      if (m >= 2) run(n);
      // Always-on mode: a brown-out must pull the core back into reset.
      if (m == 3)
      begin
        bod = 1; cyc(3); bod = 0;
        chk(crst, 1'b1);
        run(n);
      end
      $display("test %0d done", m);
    end
    finish_test;
  end
endmodule
